// *** ode_pkg.sv ***
/*
  ode_pkg: shared constants for the pwm output disable guard.
  Holds the register map, field positions, reset values, cause bit indices
  and the bus slave state type. Assumes 32-bit Avalon-MM byte addressing.
*/
package ode_pkg;

  // bus geometry
  localparam int ADDR_W  = 6;
  localparam int DATA_W  = 32;
  localparam int BE_W    = DATA_W / 8;

  // block geometry
  localparam int PIN_N   = 6;   // ch3 b,d / ch4 a,c / ch4 b,d
  localparam int PAIR_N  = 3;
  localparam int FAULT_N = 3;
  localparam int CAUSE_N = 9;
  localparam int WONCE_N = 5;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_INLVL  = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_OUTLVL = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_ACTLVL = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_CTRL2  = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_CMPSEL = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_SWREQ  = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_MASK   = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_LIVE   = 6'h20;

  // write-once register slots
  localparam int W_INLVL  = 0;
  localparam int W_OUTLVL = 1;
  localparam int W_ACTLVL = 2;
  localparam int W_CTRL2  = 3;
  localparam int W_CMPSEL = 4;

  // reset values
  localparam logic [DATA_W-1:0] RST_INLVL  = 32'h0000_0007;
  localparam logic [DATA_W-1:0] RST_OUTLVL = 32'h0000_0007;
  localparam logic [DATA_W-1:0] RST_ACTLVL = 32'h0000_003F;
  localparam logic [DATA_W-1:0] RST_CTRL2  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_CMPSEL = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_ZERO   = 32'h0000_0000;

  // control two fields
  localparam int GRP_CH3 = 0;
  localparam int GRP_CH4 = 1;

  // cause / status bit positions
  localparam int C_FAULT  = 0;  // 0..2 fault inputs
  localparam int C_SHORT  = 3;  // 3..5 pair shorts
  localparam int C_OSC    = 6;
  localparam int C_CMP    = 7;
  localparam int C_SW     = 8;

  // live register fields
  localparam int L_HIZ    = 0;
  localparam int L_PIN    = 8;  // 8..13 raw timer levels

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } ode_bus_state_t;

endpackage

// *** ode_reg_if.sv ***
/*
  ode_reg_if: register access path between the bus slave and the register
  file. Write enable is a single cycle strobe; read data is combinational.
*/
`timescale 1ns/10ps
interface ode_reg_if;
  logic [ode_pkg::ADDR_W-1:0] addr;
  logic [ode_pkg::DATA_W-1:0] wrData;
  logic [ode_pkg::BE_W-1:0]   byteEn;
  logic                       wrEn;
  logic [ode_pkg::DATA_W-1:0] rdData;

  modport bus  (output addr, output wrData, output byteEn, output wrEn,
                input rdData);
  modport regs (input addr, input wrData, input byteEn, input wrEn,
                output rdData);
endinterface

// *** ode_bus_slave.sv ***
/*
  ode_bus_slave: Avalon-MM slave front end with waitrequest.
  Every access takes one wait cycle; the master must hold its request
  until it sees waitrequest low.
*/
`timescale 1ns/10ps
module ode_bus_slave (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  input  wire logic [ode_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [ode_pkg::DATA_W-1:0]  avs_writedata,
  input  wire logic [ode_pkg::BE_W-1:0]    avs_byteenable,
  output logic      [ode_pkg::DATA_W-1:0]  avs_readdata,
  output logic                             avs_waitrequest,
  ode_reg_if.bus                           rif
);
  ode_pkg::ode_bus_state_t state_r;

  // one wait cycle gives the read data a full cycle to settle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= ode_pkg::BUS_IDLE;
    end else if (state_r == ode_pkg::BUS_DONE) begin
      state_r <= ode_pkg::BUS_IDLE;
    end else if (avs_read || avs_write) begin
      state_r <= ode_pkg::BUS_DONE;
    end
  end

  // read data captured while waitrequest is still high
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avs_readdata <= ode_pkg::RST_ZERO;
    end else if (state_r == ode_pkg::BUS_IDLE && avs_read) begin
      avs_readdata <= rif.rdData;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) &&
                           (state_r != ode_pkg::BUS_DONE);
  assign rif.addr   = avs_address;
  assign rif.wrData = avs_writedata;
  assign rif.byteEn = avs_byteenable;
  assign rif.wrEn   = avs_write && (state_r == ode_pkg::BUS_DONE);
endmodule // ode_bus_slave

// *** ode_short_detect.sv ***
/*
  ode_short_detect: flags each complementary pair whose two outputs sit at
  their active level in the same cycle. Inputs are the timer's own drive
  levels, synchronous to ref_clk.
*/
`timescale 1ns/10ps
module ode_short_detect #(
  parameter int PAIR_N = ode_pkg::PAIR_N
) (
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire logic [2*PAIR_N-1:0] pinLevel,
  input  wire logic [2*PAIR_N-1:0] activeLevel,
  output logic      [PAIR_N-1:0]   shortSeen
);
  // one registered comparator per pair; a single matching cycle is enough
  for (genvar p = 0; p < PAIR_N; p++) begin : g_pair
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        shortSeen[p] <= 1'b0;
      end else begin
        shortSeen[p] <= (pinLevel[2*p]   == activeLevel[2*p]) &&
                        (pinLevel[2*p+1] == activeLevel[2*p+1]);
      end
    end
  end
endmodule // ode_short_detect

// *** ode_output_disable_guard.sv ***
/*
  ode_output_disable_guard: forces the timer's six pwm pins to high
  impedance on fault inputs, pair shorts, software request, oscillator
  stop or selected comparator detection, with write-once configuration.
  Assumes fault inputs, timer levels and detect inputs synchronous to
  ref_clk; the pad drives the pin only while its output enable is high.
*/
//
// Overview of operation
// - any enabled fault input low forces high impedance
// - ch3 b/d both active means short, disable
// - ch4 a/c both active means short, disable
// - ch4 b/d both active means short, disable
// - software request bit set forces high impedance
// - oscillator stop forces high impedance
// - selected comparator detection forces high impedance
// - configuration registers accept only the first write
`timescale 1ns/10ps
module ode_output_disable_guard #(
  parameter int CMP_N = 3
) (
  input  wire logic                          ref_clk,
  input  wire logic                          srst,
  input  wire logic [ode_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [ode_pkg::DATA_W-1:0]    avs_writedata,
  input  wire logic [ode_pkg::BE_W-1:0]      avs_byteenable,
  output logic      [ode_pkg::DATA_W-1:0]    avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          faultInputFirstN,
  input  wire logic                          faultInputSecondN,
  input  wire logic                          faultInputThirdN,
  input  wire logic                          oscStopDetect,
  input  wire logic [CMP_N-1:0]              cmpDetect,
  input  wire logic [ode_pkg::PIN_N-1:0]     timerPwmOut,
  output logic      [ode_pkg::PIN_N-1:0]     pwmPinOut,
  output logic      [ode_pkg::PIN_N-1:0]     pwmPinOe,
  output logic                               irq
);

  ode_reg_if rif ();

  // write-once configuration and plain registers
  logic [ode_pkg::DATA_W-1:0]  inLvl_r;
  logic [ode_pkg::DATA_W-1:0]  outLvl_r;
  logic [ode_pkg::DATA_W-1:0]  actLvl_r;
  logic [ode_pkg::DATA_W-1:0]  ctrl2_r;
  logic [ode_pkg::DATA_W-1:0]  cmpSel_r;
  logic [ode_pkg::WONCE_N-1:0] written_r;
  logic                        swReq_r;
  logic [ode_pkg::CAUSE_N-1:0] status_r;
  logic [ode_pkg::CAUSE_N-1:0] status_nxt;
  logic [ode_pkg::CAUSE_N-1:0] mask_r;
  logic [ode_pkg::CAUSE_N-1:0] cause;
  logic [ode_pkg::CAUSE_N-1:0] clrReq;
  logic [ode_pkg::PAIR_N-1:0]  shortSeen;
  logic [ode_pkg::PAIR_N-1:0]  pairEn;
  logic [ode_pkg::FAULT_N-1:0] faultLow;
  logic                        hizNow;

  // merge written byte lanes over the old value
  function automatic logic [ode_pkg::DATA_W-1:0] laneMerge(
    input logic [ode_pkg::DATA_W-1:0] oldVal,
    input logic [ode_pkg::DATA_W-1:0] newVal,
    input logic [ode_pkg::BE_W-1:0]   be
  );
    logic [ode_pkg::DATA_W-1:0] res;
    res = oldVal;
    for (int b = 0; b < ode_pkg::BE_W; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = newVal[8*b +: 8];
      end
    end
    return res;
  endfunction

  // a write strobe that lands on a given offset
  function automatic logic hitWrite(
    input logic                      en,
    input logic [ode_pkg::ADDR_W-1:0] a,
    input logic [ode_pkg::ADDR_W-1:0] off
  );
    return en && (a == off);
  endfunction

  ode_bus_slave u_bus (
    .ref_clk         (ref_clk),
    .srst            (srst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .rif             (rif.bus)
  );

  ode_short_detect #(
    .PAIR_N (ode_pkg::PAIR_N)
  ) u_short (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .pinLevel    (timerPwmOut),
    .activeLevel (actLvl_r[ode_pkg::PIN_N-1:0]),
    .shortSeen   (shortSeen)
  );

  // first write after reset sticks; later writes are dropped silently
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      inLvl_r <= ode_pkg::RST_INLVL;
    end else if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_INLVL) &&
                 !written_r[ode_pkg::W_INLVL]) begin
      inLvl_r <= laneMerge(inLvl_r, rif.wrData, rif.byteEn);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      outLvl_r <= ode_pkg::RST_OUTLVL;
    end else if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_OUTLVL) &&
                 !written_r[ode_pkg::W_OUTLVL]) begin
      outLvl_r <= laneMerge(outLvl_r, rif.wrData, rif.byteEn);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      actLvl_r <= ode_pkg::RST_ACTLVL;
    end else if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_ACTLVL) &&
                 !written_r[ode_pkg::W_ACTLVL]) begin
      actLvl_r <= laneMerge(actLvl_r, rif.wrData, rif.byteEn);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl2_r <= ode_pkg::RST_CTRL2;
    end else if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_CTRL2) &&
                 !written_r[ode_pkg::W_CTRL2]) begin
      ctrl2_r <= laneMerge(ctrl2_r, rif.wrData, rif.byteEn);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmpSel_r <= ode_pkg::RST_CMPSEL;
    end else if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_CMPSEL) &&
                 !written_r[ode_pkg::W_CMPSEL]) begin
      cmpSel_r <= laneMerge(cmpSel_r, rif.wrData, rif.byteEn);
    end
  end

  // lock flags: any write, whatever lanes, uses up the single chance
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      written_r <= '0;
    end else begin
      if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_INLVL))
        written_r[ode_pkg::W_INLVL] <= 1'b1;
      if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_OUTLVL))
        written_r[ode_pkg::W_OUTLVL] <= 1'b1;
      if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_ACTLVL))
        written_r[ode_pkg::W_ACTLVL] <= 1'b1;
      if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_CTRL2))
        written_r[ode_pkg::W_CTRL2] <= 1'b1;
      if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_CMPSEL))
        written_r[ode_pkg::W_CMPSEL] <= 1'b1;
    end
  end

  // software request is a level held until software writes it back to 0
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      swReq_r <= 1'b0;
    end else if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_SWREQ) &&
                 rif.byteEn[0]) begin
      swReq_r <= rif.wrData[0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mask_r <= '0;
    end else if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_MASK)) begin
      mask_r <= laneMerge({{(ode_pkg::DATA_W-ode_pkg::CAUSE_N){1'b0}},
                           mask_r}, rif.wrData,
                          rif.byteEn)[ode_pkg::CAUSE_N-1:0];
    end
  end

  // cause vector; short detection only counts for enabled pin groups
  assign faultLow = ~{faultInputThirdN, faultInputSecondN,
                      faultInputFirstN};
  assign pairEn[0] = outLvl_r[0] && ctrl2_r[ode_pkg::GRP_CH3];
  assign pairEn[1] = outLvl_r[1] && ctrl2_r[ode_pkg::GRP_CH4];
  assign pairEn[2] = outLvl_r[2] && ctrl2_r[ode_pkg::GRP_CH4];

  always_comb begin
    cause = '0;
    cause[ode_pkg::C_FAULT +: ode_pkg::FAULT_N] =
      faultLow & inLvl_r[ode_pkg::FAULT_N-1:0];
    cause[ode_pkg::C_SHORT]     = shortSeen[0] && pairEn[0];
    cause[ode_pkg::C_SHORT + 1] = shortSeen[1] && pairEn[1];
    cause[ode_pkg::C_SHORT + 2] = shortSeen[2] && pairEn[2];
    cause[ode_pkg::C_OSC] = oscStopDetect;
    cause[ode_pkg::C_CMP] = |(cmpDetect & cmpSel_r[CMP_N-1:0]);
    cause[ode_pkg::C_SW]  = swReq_r;
  end

  // write-one-to-clear, refused while the cause persists; set wins
  always_comb begin
    clrReq = '0;
    if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_STATUS) &&
        rif.byteEn[0]) begin
      clrReq[7:0] = rif.wrData[7:0];
    end
    if (hitWrite(rif.wrEn, rif.addr, ode_pkg::OFF_STATUS) &&
        rif.byteEn[1]) begin
      clrReq[ode_pkg::CAUSE_N-1:8] = rif.wrData[ode_pkg::CAUSE_N-1:8];
    end
    status_nxt = (status_r & ~(clrReq & ~cause)) | cause;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign hizNow = |status_nxt;

  // pins: drive the timer level, release all six while any flag stands
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwmPinOut <= '0;
      pwmPinOe  <= '0;
    end else begin
      pwmPinOut <= timerPwmOut;
      pwmPinOe  <= {ode_pkg::PIN_N{!hizNow}};
    end
  end

  // level interrupt while a flag whose mask_r bit is set stands
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_nxt & mask_r);
    end
  end

  // readback; unmapped offsets read zero
  always_comb begin
    rif.rdData = ode_pkg::RST_ZERO;
    if (rif.addr == ode_pkg::OFF_INLVL) begin
      rif.rdData = inLvl_r;
    end else if (rif.addr == ode_pkg::OFF_OUTLVL) begin
      rif.rdData = outLvl_r;
    end else if (rif.addr == ode_pkg::OFF_ACTLVL) begin
      rif.rdData = actLvl_r;
    end else if (rif.addr == ode_pkg::OFF_CTRL2) begin
      rif.rdData = ctrl2_r;
    end else if (rif.addr == ode_pkg::OFF_CMPSEL) begin
      rif.rdData = cmpSel_r;
    end else if (rif.addr == ode_pkg::OFF_SWREQ) begin
      rif.rdData[0] = swReq_r;
    end else if (rif.addr == ode_pkg::OFF_STATUS) begin
      rif.rdData[ode_pkg::CAUSE_N-1:0] = status_r;
    end else if (rif.addr == ode_pkg::OFF_MASK) begin
      rif.rdData[ode_pkg::CAUSE_N-1:0] = mask_r;
    end else if (rif.addr == ode_pkg::OFF_LIVE) begin
      rif.rdData[ode_pkg::L_HIZ] = |status_r;
      rif.rdData[ode_pkg::L_PIN +: ode_pkg::PIN_N] = timerPwmOut;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_fault_first_hiz: assert property (
    (!faultInputFirstN && inLvl_r[0]) |=> !pwmPinOe[0] && status_r[0])
    else $error("first fault input did not release the pins");

  a_fault_third_flag: assert property (
    (!faultInputThirdN && inLvl_r[2]) |=> status_r[2] && !pwmPinOe[5])
    else $error("third fault input did not set its flag");

  a_short_ch3_pair: assert property (
    ((timerPwmOut[0] == actLvl_r[0]) && (timerPwmOut[1] == actLvl_r[1])
     && pairEn[0]) ##1 pairEn[0] |=> status_r[3] && !pwmPinOe[1])
    else $error("ch3 pair short not caught two cycles later");

  a_short_ch4_ac: assert property (
    ((timerPwmOut[2] == actLvl_r[2]) && (timerPwmOut[3] == actLvl_r[3])
     && pairEn[1]) ##1 pairEn[1] |=> status_r[4] && !pwmPinOe[2])
    else $error("ch4 a/c short not caught two cycles later");

  a_short_ch4_bd: assert property (
    ((timerPwmOut[4] == actLvl_r[4]) && (timerPwmOut[5] == actLvl_r[5])
     && pairEn[2]) ##1 pairEn[2] |=> status_r[5] && !pwmPinOe[4])
    else $error("ch4 b/d short not caught two cycles later");

  a_soft_request_hiz: assert property (
    swReq_r |=> status_r[8] && (pwmPinOe == '0))
    else $error("software request left pins driven");

  a_osc_stop_hiz: assert property (
    oscStopDetect |=> status_r[6] && (pwmPinOe == '0))
    else $error("oscillator stop left pins driven");

  a_cmp_select_hiz: assert property (
    |(cmpDetect & cmpSel_r[CMP_N-1:0]) |=> status_r[7] && !pwmPinOe[3])
    else $error("selected comparator detection ignored");

  a_write_once_act: assert property (
    written_r[ode_pkg::W_ACTLVL] |=> $stable(actLvl_r))
    else $error("active level register changed after first write");

  a_write_once_ctrl: assert property (
    written_r[ode_pkg::W_CTRL2] |=> $stable(ctrl2_r))
    else $error("control register two changed after first write");

  a_flag_hold_hiz: assert property (
    (|status_r) |-> ##[0:1] (pwmPinOe == '0) ##0
    ($past(|status_r) || (|status_r)))
    else $error("pins driven while a disable flag stands");

  a_cause_keeps_flag: assert property (
    (status_r[6] && oscStopDetect) |=> status_r[6])
    else $error("flag cleared while its cause persisted");

endmodule // ode_output_disable_guard

// *** ode_gate_drive_model.sv ***
/*
  ode_gate_drive_model: far side of the guard, inverter gate driver inputs
  and the external fault sources. Assumes the gate driver inputs carry a
  pull-down, so a released pad reads as switch off.
*/
`timescale 1ns/10ps
module ode_gate_drive_model (
  input  wire logic [ode_pkg::PIN_N-1:0] pwmPinOut,
  input  wire logic [ode_pkg::PIN_N-1:0] pwmPinOe,
  input  wire logic [2:0]                faultReq,
  output logic      [ode_pkg::PIN_N-1:0] gateLevel,
  output logic                           faultFirstN,
  output logic                           faultSecondN,
  output logic                           faultThirdN
);
  // released pads fall to the pull-down, never keep the last value
  always_comb begin
    for (int i = 0; i < ode_pkg::PIN_N; i++) begin
      gateLevel[i] = pwmPinOe[i] ? pwmPinOut[i] : 1'b0;
    end
  end

  // each fault source pulls its line low while its fault stands
  assign faultFirstN  = ~faultReq[0];
  assign faultSecondN = ~faultReq[1];
  assign faultThirdN  = ~faultReq[2];
endmodule // ode_gate_drive_model

// *** tb.sv ***
/*
  tb: self-checking bench for the output disable guard.
  Assumes the guard answers each bus access after one wait cycle and that
  the gate drive model stands in for the pads and fault sources.
*/
`timescale 1ns/10ps
module tb;
  localparam logic [5:0] IDLE_PWM = 6'h15;  // one side of each pair on

  logic                         ref_clk;
  logic                         srst;
  logic [ode_pkg::ADDR_W-1:0]   address;
  logic                         rdReq;
  logic                         wrReq;
  logic [ode_pkg::DATA_W-1:0]   wrData;
  logic [ode_pkg::BE_W-1:0]     byteEn;
  logic [ode_pkg::DATA_W-1:0]   rdData;
  logic                         waitReq;
  logic [2:0]                   faultReq;
  logic                         faultFirstN;
  logic                         faultSecondN;
  logic                         faultThirdN;
  logic                         oscStop;
  logic [2:0]                   cmpDet;
  logic [5:0]                   timerPwm;
  logic [5:0]                   pinOut;
  logic [5:0]                   pinOe;
  logic [5:0]                   gateLevel;
  logic                         irq;
  int                           nMismatch;
  int                           nCompared;
  logic [ode_pkg::ADDR_W-1:0]   cfgOff [5];
  logic [ode_pkg::DATA_W-1:0]   cfgRst [5];
  logic [ode_pkg::DATA_W-1:0]   cfgNew [5];

  ode_output_disable_guard #(.CMP_N(3)) u_ode_output_disable_guard (
    .ref_clk(ref_clk), .srst(srst), .avs_address(address),
    .avs_read(rdReq), .avs_write(wrReq), .avs_writedata(wrData),
    .avs_byteenable(byteEn), .avs_readdata(rdData),
    .avs_waitrequest(waitReq), .faultInputFirstN(faultFirstN),
    .faultInputSecondN(faultSecondN), .faultInputThirdN(faultThirdN),
    .oscStopDetect(oscStop), .cmpDetect(cmpDet), .timerPwmOut(timerPwm),
    .pwmPinOut(pinOut), .pwmPinOe(pinOe), .irq(irq));

  ode_gate_drive_model u_ode_gate_drive_model (
    .pwmPinOut(pinOut), .pwmPinOe(pinOe), .faultReq(faultReq),
    .gateLevel(gateLevel), .faultFirstN(faultFirstN),
    .faultSecondN(faultSecondN), .faultThirdN(faultThirdN));

  // free-running bench clock, 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_port(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    nCompared++;
    if (g !== e) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d,
                        input logic [3:0] be);
    @(posedge ref_clk);
    address <= a;
    wrData  <= d;
    byteEn  <= be;
    wrReq   <= 1'b1;
    do @(posedge ref_clk); while (waitReq !== 1'b0);
    wrReq <= 1'b0;
  endtask

  task automatic rd_cmp(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    @(posedge ref_clk);
    address <= a;
    rdReq   <= 1'b1;
    do @(posedge ref_clk); while (waitReq !== 1'b0);
    d = rdData;
    rdReq <= 1'b0;
    chk_word($sformatf("reg %h", a), e, d);
  endtask

  // raise or drop one disable cause, indexed as its status bit
  task automatic set_cause(input int k, input logic on);
    @(posedge ref_clk);
    if (k < 3) faultReq[k] <= on;
    else if (k < 6) timerPwm <= on ? IDLE_PWM | (6'h3 << (2*(k-3)))
                                   : IDLE_PWM;
    else if (k == 6) oscStop <= on;
    else if (k == 7) cmpDet <= on ? 3'h1 : 3'h0;
    else bus_wr(ode_pkg::OFF_SWREQ, {31'h0, on}, 4'h1);
  endtask

  task automatic summarize();
    $display("compared %0d mismatched %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #80000;
    nMismatch++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    nMismatch = 0;
    nCompared = 0;
    srst = 1'b1;
    address = 6'h00;
    rdReq = 1'b0;
    wrReq = 1'b0;
    wrData = 32'h0000_0000;
    byteEn = 4'h0;
    faultReq = 3'h0;
    oscStop = 1'b0;
    cmpDet = 3'h0;
    timerPwm = IDLE_PWM;
    cfgOff = '{ode_pkg::OFF_INLVL, ode_pkg::OFF_OUTLVL, ode_pkg::OFF_ACTLVL,
               ode_pkg::OFF_CTRL2, ode_pkg::OFF_CMPSEL};
    cfgRst = '{ode_pkg::RST_INLVL, ode_pkg::RST_OUTLVL, ode_pkg::RST_ACTLVL,
               ode_pkg::RST_CTRL2, ode_pkg::RST_CMPSEL};
    cfgNew = '{32'h0000_0007, 32'h0000_0007, 32'h0000_003F, 32'h0000_0003,
               32'h0000_0007};
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk_port("pin enable", 8'h3F, {2'b00, pinOe});
    chk_port("gate level", {2'b00, IDLE_PWM}, {2'b00, gateLevel});
    $display("test reset done");

    // first write sticks, later full-word writes are dropped
    for (int i = 0; i < 5; i++) begin
      rd_cmp(cfgOff[i], cfgRst[i]);
      bus_wr(cfgOff[i], cfgNew[i], (i == 3) ? 4'h1 : 4'hF);
      bus_wr(cfgOff[i], 32'h0000_0000, 4'hF);
      rd_cmp(cfgOff[i], cfgNew[i]);
    end
    rd_cmp(ode_pkg::OFF_MASK, ode_pkg::RST_ZERO);
    bus_wr(ode_pkg::OFF_MASK, 32'h0000_00FE, 4'h1);
    bus_wr(ode_pkg::OFF_MASK, 32'h0000_0100, 4'h2);
    rd_cmp(ode_pkg::OFF_MASK, 32'h0000_01FE);
    bus_wr(6'h30, 32'hFFFF_FFFF, 4'hF);
    rd_cmp(6'h30, 32'h0000_0000);
    $display("test config done");

    // every cause forces release and holds it; cause 0 also shows a clear is refused while it stands
    for (int k = 0; k < 9; k++) begin
      set_cause(k, 1'b1);
      repeat (2) @(posedge ref_clk);
      #1;
      chk_port("pin enable", 8'h00, {2'b00, pinOe});
      chk_port("gate level", 8'h00, {2'b00, gateLevel});
      chk_port("interrupt", {7'h0, k != 0}, {7'h0, irq});
      rd_cmp(ode_pkg::OFF_STATUS, 32'h1 << k);
      if (k == 0) begin
        bus_wr(ode_pkg::OFF_STATUS, 32'h0000_0001, 4'hF);
        rd_cmp(ode_pkg::OFF_STATUS, 32'h0000_0001);
      end
      set_cause(k, 1'b0);
      repeat (2) @(posedge ref_clk);
      #1;
      chk_port("held enable", 8'h00, {2'b00, pinOe});
      rd_cmp(ode_pkg::OFF_LIVE, 32'h1 | (32'(IDLE_PWM) << 8));
      bus_wr(ode_pkg::OFF_STATUS, 32'h1 << k, 4'hF);
      @(posedge ref_clk);
      #1;
      chk_port("pin enable", 8'h3F, {2'b00, pinOe});
      chk_port("interrupt", 8'h00, {7'h0, irq});
      rd_cmp(ode_pkg::OFF_STATUS, ode_pkg::RST_ZERO);
      $display("test cause %0d done", k);
    end
    summarize();
  end
endmodule // tb
